// [core/dls_sequencer.v]
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dls_consts.vh"
module dls_sequencer (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Tray and clamp switches
  input wire tray_push,
  input wire panel_load,
  input wire tray_down_sw,
  input wire clamp_sw,
  // Pickup sensors
  input wire tilt_reflect,
  input wire carriage_ref,
  input wire spindle_step,
  input wire lens_end,
  input wire focus_lock,
  input wire [7:0] turntable_pct,
  // Motor and servo controls
  output reg tilt_motor_in,
  output reg spindle_fwd,
  output reg spindle_rev,
  output reg lens_return,
  output reg focus_start,
  output reg turntable_on,
  output reg turntable_audio_rate,
  output reg radial_enable,
  // Status to the user processor
  output reg status_searching,
  output reg disc_video,
  output reg disc_small,
  output reg no_disc
);

  localparam [10:0] ST_IDLE = 11'h001;
  localparam [10:0] ST_LOAD = 11'h002;
  localparam [10:0] ST_CLAMP = 11'h004;
  localparam [10:0] ST_SENSE = 11'h008;
  localparam [10:0] ST_FIND_REF = 11'h010;
  localparam [10:0] ST_TO_START = 11'h020;
  localparam [10:0] ST_CHECK = 11'h040;
  localparam [10:0] ST_NO_DISC = 11'h080;
  localparam [10:0] ST_FOCUS = 11'h100;
  localparam [10:0] ST_SPIN = 11'h200;
  localparam [10:0] ST_TRACK = 11'h400;

  reg [10:0] state;
  reg [10:0] next_state;
  reg run;
  reg restart;
  reg [15:0] start_steps;
  reg [7:0] radial_pct;
  reg aw_held, w_held;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg track_step, step_last;
  wire [15:0] position;
  wire ref_found;
  wire aw_take, w_take, do_write, ar_take;
  wire aw_held_nxt, w_held_nxt;
  wire [31:0] wmask;
  wire [31:0] status_word;
  wire load_req, step_edge, carriage_moving;
  genvar gi;

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_mask
      assign wmask[gi*8+7:gi*8] = {8{w_strb_q[gi]}};
    end
  endgenerate

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign aw_held_nxt = (aw_held | aw_take) & ~do_write;
  assign w_held_nxt = (w_held | w_take) & ~do_write;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign load_req = tray_push | panel_load;
  assign step_edge = spindle_step & ~step_last;
  assign carriage_moving = spindle_fwd | spindle_rev;

  assign status_word = {5'h00, state, 9'h000,
                        ref_found, clamp_sw & (state != ST_IDLE),
                        radial_enable, no_disc, disc_small, disc_video,
                        status_searching};

  dls_carriage u_carriage (
    .clock(clock),
    .reset_n(reset_n),
    .step_in(spindle_step),
    .moving(carriage_moving),
    .dir_fwd(spindle_fwd),
    .ref_in(carriage_ref),
    .arm(state == ST_SENSE),
    .ref_value(start_steps),
    .position(position),
    .ref_found(ref_found)
  );

  // Register writes. Both channels are held until the pair is complete.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DLS_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      run <= `DLS_RST_RUN;
      restart <= 1'b0;
      start_steps <= `DLS_RST_START_STEPS;
      radial_pct <= `DLS_RST_RADIAL_PCT;
    end else begin
      restart <= 1'b0;
      aw_held <= aw_held_nxt;
      w_held <= w_held_nxt;
      s_axi_awready <= ~aw_held_nxt;
      s_axi_wready <= ~w_held_nxt;
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `DLS_RESP_OKAY;
        case ({aw_addr_q[7:2], 2'b00})
          `DLS_ADDR_CONTROL: begin
            if (w_strb_q[0]) begin
              run <= w_data_q[`DLS_CTRL_RUN];
              restart <= w_data_q[`DLS_CTRL_RESTART];
            end
          end
          `DLS_ADDR_START_STEPS: begin
            start_steps <= (start_steps & ~wmask[15:0]) | (w_data_q[15:0] & wmask[15:0]);
          end
          `DLS_ADDR_RADIAL_PCT: begin
            radial_pct <= (radial_pct & ~wmask[7:0]) | (w_data_q[7:0] & wmask[7:0]);
          end
          `DLS_ADDR_STATUS, `DLS_ADDR_POSITION: s_axi_bresp <= `DLS_RESP_OKAY;
          default: begin
            s_axi_bresp <= `DLS_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Register reads, answered one cycle after the address is taken.
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DLS_RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `DLS_RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
          `DLS_ADDR_CONTROL: s_axi_rdata <= {31'h00000000, run};
          `DLS_ADDR_START_STEPS: s_axi_rdata <= {16'h0000, start_steps};
          `DLS_ADDR_STATUS: s_axi_rdata <= status_word;
          `DLS_ADDR_POSITION: s_axi_rdata <= {16'h0000, position};
          `DLS_ADDR_RADIAL_PCT: s_axi_rdata <= {24'h000000, radial_pct};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DLS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Sequence. Each state leaves on its own condition (TRACK has none), on clamp loss (except IDLE and LOAD), on restart or when run is cleared; else it holds.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (run && load_req) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (tray_down_sw) begin
          next_state = ST_CLAMP;
        end
      end
      ST_CLAMP: begin
        if (clamp_sw) begin
          next_state = ST_SENSE;
        end
      end
      ST_SENSE: begin
        if (tilt_reflect) begin
          next_state = ST_FOCUS;
        end else begin
          next_state = ST_FIND_REF;
        end
      end
      ST_FIND_REF: begin
        if (ref_found) begin
          next_state = ST_TO_START;
        end
      end
      ST_TO_START: begin
        if (position == 16'h0000) begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (tilt_reflect) begin
          next_state = ST_FOCUS;
        end else begin
          next_state = ST_NO_DISC;
        end
      end
      ST_NO_DISC: begin
        if (load_req) begin
          next_state = ST_LOAD;
        end
      end
      ST_FOCUS: begin
        if (focus_lock) begin
          next_state = ST_SPIN;
        end
      end
      ST_SPIN: begin
        if (turntable_pct >= radial_pct) begin
          next_state = ST_TRACK;
        end
      end
      ST_TRACK: next_state = ST_TRACK;
      default: next_state = ST_IDLE;
    endcase
    // Losing the clamp means the disc may be loose, so the spin-up is dropped.
    if (state != ST_IDLE && state != ST_LOAD && !clamp_sw) begin
      next_state = ST_CLAMP;
    end
    if (restart || !run) begin
      next_state = ST_IDLE;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      step_last <= 1'b0;
      track_step <= 1'b0;
      tilt_motor_in <= 1'b0;
      spindle_fwd <= 1'b0;
      spindle_rev <= 1'b0;
      lens_return <= 1'b0;
      focus_start <= 1'b0;
      turntable_on <= 1'b0;
      turntable_audio_rate <= 1'b0;
      radial_enable <= 1'b0;
      status_searching <= 1'b0;
      disc_video <= 1'b0;
      disc_small <= 1'b0;
      no_disc <= 1'b0;
    end else begin
      state <= next_state;
      step_last <= spindle_step;
      tilt_motor_in <= (next_state == ST_LOAD);
      status_searching <= (next_state == ST_FIND_REF) ||
                          (next_state == ST_TO_START);
      spindle_rev <= (next_state == ST_TO_START);
      focus_start <= (next_state == ST_FOCUS) || (next_state == ST_SPIN) ||
                     (next_state == ST_TRACK);
      turntable_on <= (next_state == ST_SPIN) || (next_state == ST_TRACK);
      radial_enable <= (next_state == ST_TRACK);
      no_disc <= (next_state == ST_NO_DISC);
      if (next_state == ST_IDLE || next_state == ST_LOAD) begin
        disc_video <= 1'b0;
        disc_small <= 1'b0;
      end else if (state == ST_SENSE && next_state == ST_FOCUS) begin
        disc_video <= 1'b1;
      end else if (state == ST_CHECK && next_state == ST_FOCUS) begin
        disc_small <= 1'b1;
      end
      // Small discs read their contents at the audio rate first.
      turntable_audio_rate <= ((next_state == ST_SPIN) || (next_state == ST_TRACK)) &&
                              (disc_small || (state == ST_CHECK)) && !disc_video;
      // The lens recentres while the carriage advances one step; then the cycle repeats.
      if (next_state != ST_TRACK) begin
        track_step <= 1'b0;
      end else if (!track_step && lens_end) begin
        track_step <= 1'b1;
      end else if (track_step && step_edge) begin
        track_step <= 1'b0;
      end
      spindle_fwd <= (next_state == ST_FIND_REF) ||
                     ((next_state == ST_TRACK) &&
                      ((!track_step && lens_end) || (track_step && !step_edge)));
      lens_return <= (next_state == ST_TRACK) &&
                     ((!track_step && lens_end) || (track_step && !step_edge));
    end
  end

endmodule

// [core/dls_consts.vh]
`ifndef DLS_CONSTS_VH
`define DLS_CONSTS_VH

// Register byte offsets.
`define DLS_ADDR_CONTROL 8'h00
`define DLS_ADDR_START_STEPS 8'h04
`define DLS_ADDR_STATUS 8'h08
`define DLS_ADDR_POSITION 8'h0c
`define DLS_ADDR_RADIAL_PCT 8'h10

// Control fields.
`define DLS_CTRL_RUN 0
`define DLS_CTRL_RESTART 1

// Status fields.
`define DLS_STAT_SEARCHING 0
`define DLS_STAT_VIDEO 1
`define DLS_STAT_SMALL 2
`define DLS_STAT_NO_DISC 3
`define DLS_STAT_RADIAL 4
`define DLS_STAT_CLAMPED 5
`define DLS_STAT_REF_FOUND 6
`define DLS_STAT_STATE_LSB 16

// Reset values.
`define DLS_RST_RUN 1'b1
`define DLS_RST_START_STEPS 16'h0320
`define DLS_RST_RADIAL_PCT 8'h3c

// Carriage travel per counted step, in microns.
`define DLS_STEP_MICRONS 50

// AXI responses.
`define DLS_RESP_OKAY 2'b00
`define DLS_RESP_SLVERR 2'b10

`endif

// [core/dls_carriage.v]
`timescale 1ns/1ps
// Tracks the pickup carriage in pulley steps, counted down toward the disc start.
module dls_carriage (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Motion
  input wire step_in,
  input wire moving,
  input wire dir_fwd,
  // Reference
  input wire ref_in,
  input wire arm,
  input wire [15:0] ref_value,
  // Results
  output reg [15:0] position,
  output reg ref_found
);

  reg step_last;
  reg ref_last;
  wire step_edge;
  wire ref_edge;

  assign step_edge = step_in & ~step_last;
  assign ref_edge = ref_in & ~ref_last;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      step_last <= 1'b0;
      ref_last <= 1'b0;
      position <= 16'h0000;
      ref_found <= 1'b0;
    end else begin
      step_last <= step_in;
      ref_last <= ref_in;
      if (arm) begin
        ref_found <= 1'b0;
      end else if (ref_edge && !ref_found) begin
        // Only the first edge is trusted; later edges are carriage wobble.
        ref_found <= 1'b1;
      end
      if (!arm && ref_edge && !ref_found) begin
        position <= ref_value;
      end else if (step_edge && moving) begin
        // One step is one pulley increment of carriage travel.
        if (dir_fwd) begin
          position <= position + 16'h0001;
        end else begin
          position <= position - 16'h0001;
        end
      end
    end
  end

endmodule

// [verif/dls_sequencer_asserts.sv]
`timescale 1ns/1ps
module dls_sequencer_asserts (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Sensors and requests
  input wire tray_push,
  input wire panel_load,
  input wire tray_down_sw,
  input wire clamp_sw,
  input wire tilt_reflect,
  input wire lens_end,
  input wire focus_lock,
  input wire [7:0] turntable_pct,
  // Controls and status
  input wire tilt_motor_in,
  input wire spindle_fwd,
  input wire spindle_rev,
  input wire lens_return,
  input wire focus_start,
  input wire turntable_on,
  input wire turntable_audio_rate,
  input wire radial_enable,
  input wire status_searching,
  input wire disc_video,
  input wire no_disc
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  load_request_a: assert property ($rose(tilt_motor_in) |-> $past(tray_push | panel_load))
    else $error("tilt motor started without request");
  tray_stop_a: assert property (tilt_motor_in && tray_down_sw |=> !tilt_motor_in)
    else $error("tilt motor kept running");
  clamp_lost_a: assert property (focus_start && !clamp_sw |=> !focus_start)
    else $error("focus kept without clamp");
  video_class_a: assert property ($rose(disc_video) |-> $past(tilt_reflect))
    else $error("video class without reflection");
  empty_class_a: assert property ($rose(no_disc) |-> !$past(tilt_reflect))
    else $error("no disc despite reflection");
  spin_after_lock_a: assert property ($rose(turntable_on) |-> $past(focus_lock))
    else $error("turntable before focus lock");
  spin_rate_a: assert property (turntable_on |-> turntable_audio_rate != disc_video)
    else $error("wrong turntable rate");
  radial_start_a: assert property ($rose(radial_enable) |-> $past(turntable_pct) >= 8'h3c)
    else $error("radial servo enabled too early");
  lens_cycle_a: assert property ($rose(lens_return) |-> spindle_fwd && $past(lens_end))
    else $error("lens return without carriage step");
  search_move_a: assert property (status_searching |-> spindle_fwd ^ spindle_rev)
    else $error("searching without carriage motion");
endmodule

bind dls_sequencer dls_sequencer_asserts dls_sequencer_asserts_inst (.*);

// [verif/dls_tray_model.sv]
`timescale 1ns/1ps
module dls_tray_model (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Scenario: 0 empty, 1 small disc, 2 large disc
  input wire [1:0] kind,
  input wire unclamp,
  // Controls
  input wire tilt_motor_in,
  input wire spindle_fwd,
  input wire spindle_rev,
  input wire lens_return,
  input wire focus_start,
  input wire turntable_on,
  // Sensors
  output logic tray_down_sw,
  output logic clamp_sw,
  output logic tilt_reflect,
  output logic carriage_ref,
  output logic spindle_step,
  output logic lens_end,
  output logic focus_lock,
  output logic [7:0] turntable_pct
);
  int pos;
  int tick;
  // The carriage starts inside the small disc edge, so the sensor sees nothing at rest.
  assign carriage_ref = pos >= 10;
  assign clamp_sw = tray_down_sw && !unclamp;
  assign tilt_reflect = tray_down_sw && (kind == 2 || kind == 1 && pos >= 3 && pos <= 7);
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pos <= 0;
      tick <= 0;
      tray_down_sw <= 1'b0;
      spindle_step <= 1'b0;
      lens_end <= 1'b0;
      focus_lock <= 1'b0;
      turntable_pct <= 8'h00;
    end else begin
      tick <= tick + 1;
      if (tilt_motor_in && tick % 16 == 0) tray_down_sw <= 1'b1;
      focus_lock <= focus_start && (focus_lock || tick % 8 == 0);
      if (!turntable_on) turntable_pct <= 8'h00;
      else if (turntable_pct < 8'h64) turntable_pct <= turntable_pct + 8'h05;
      spindle_step <= (spindle_fwd || spindle_rev) && tick % 4 == 0;
      if (spindle_step) pos <= spindle_fwd ? pos + 1 : pos - 1;
      if (lens_return) lens_end <= 1'b0;
      else if (turntable_pct > 8'h3c && tick % 32 == 0) lens_end <= 1'b1;
    end
  end
endmodule

// [verif/dls_sequencer_tb.sv]
`timescale 1ns/1ps
module dls_sequencer_tb;
  logic clock = 1'b0, reset_n = 1'b0, tray_push = 1'b0, panel_load = 1'b0, unclamp = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, lfsr = 32'h30;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] kind = 2'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire tray_down_sw, clamp_sw, tilt_reflect, carriage_ref, spindle_step, lens_end, focus_lock;
  wire [7:0] turntable_pct;
  wire tilt_motor_in, spindle_fwd, spindle_rev, lens_return, focus_start, turntable_on;
  wire turntable_audio_rate, radial_enable, status_searching, disc_video, disc_small, no_disc;
  int err_total = 0, num_checks = 0, exp_reg[int];
  logic [31:0] stat[3] = '{32'h0080_0068, 32'h0400_0074, 32'h0400_0032};
  logic seen_search;
  always #50 clock = ~clock;
  dls_sequencer dls_sequencer_inst (.*);
  dls_tray_model dls_tray_model_inst (.*);
  always @(posedge clock) seen_search <= reset_n && (seen_search || status_searching);
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    check(s_axi_bresp, a > 8'h10 ? 2 : 0);
    s_axi_bready <= 1'b0;
    if (a == 8'h00) exp_reg[0] = d & 1;
    if (a == 8'h04) exp_reg[4] = d & 32'hffff;
    if (a == 8'h10) exp_reg[16] = d & 32'hff;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    check(s_axi_rdata, want);
    check(s_axi_rresp, a > 8'h10 ? 2 : 0);
    s_axi_rready <= 1'b0;
  endtask
  // One full load from reset; the disc kind decides where the sequence settles.
  task automatic run(input int k);
    @(posedge clock);
    reset_n <= 1'b0;
    kind <= k[1:0];
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    exp_reg[0] = 1;
    exp_reg[4] = 32'h320;
    exp_reg[16] = 32'h3c;
    foreach (exp_reg[a]) rd_chk(a[7:0], exp_reg[a]);
    wr(8'h04, 32'h6);
    wr(8'h08, rnd());
    wr(8'h14, rnd());
    rd_chk(8'h14, 32'h0);
    foreach (exp_reg[a]) rd_chk(a[7:0], exp_reg[a]);
    if (rnd() & 1) tray_push <= 1'b1;
    else panel_load <= 1'b1;
    do @(posedge clock); while (!tilt_motor_in);
    tray_push <= 1'b0;
    panel_load <= 1'b0;
    do @(posedge clock); while (!(k == 0 ? no_disc : radial_enable));
    if (k > 0) do @(posedge clock); while (!lens_return);
    check(disc_video, k == 2);
    check(disc_small, k == 1);
    check(no_disc, k == 0);
    check(seen_search, k != 2);
    if (k > 0) check(turntable_audio_rate, k == 1);
    if (k > 0) check(spindle_fwd, 1);
    rd_chk(8'h08, stat[k]);
    if (k == 0) rd_chk(8'h0c, 32'h0);
  endtask
  initial begin
    run(1);
    run(0);
    wr(8'h00, 32'h0);
    rd_chk(8'h00, 32'h0);
    panel_load <= 1'b1;
    repeat (40) @(posedge clock);
    check(tilt_motor_in, 0);
    check(no_disc, 0);
    panel_load <= 1'b0;
    run(2);
    unclamp <= 1'b1;
    repeat (6) @(posedge clock);
    check(focus_start, 0);
    check(turntable_on, 0);
    unclamp <= 1'b0;
    do @(posedge clock); while (!radial_enable);
    check(turntable_audio_rate, 0);
    check(turntable_pct >= 8'h3c, 1);
    // A restart drops the spin-up and clears the classification.
    wr(8'h00, 32'h3);
    rd_chk(8'h08, 32'h0001_0000);
    results();
  end
  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    results();
  end
endmodule
